//--- logic/fsrx_top.v
// FSK receive back end: sync match, payload store, CRC check, frequency correction.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "fsrx_defines.vh"
// ****************************************************************
// Overview
// ****************************************************************
// Bits arrive on a pin pair: a level and a strobe from the data
// recovery loop. Both pass three flops; the strobe counts on its
// rising edge once the last two stages agree, so a bit is taken once.
// After a qualified preamble the matcher looks at every bit for at
// most four byte periods. A match within tolerance opens the payload
// phase: the sync word itself is never written, only what follows it.
// Payload bytes go to the local packet memory from the base pointer,
// then two check bytes follow. The running check word over payload
// and check bytes ends at zero for a clean packet.
// With the check disabled the two check bytes are stored as data and
// no packet event is raised; the sync event is the host's cue then.
// Frequency correction follows the measured error while idle and
// unlocked, freezes on preamble and opens again on a search timeout
// or at packet end.
// Limitation: the payload length comes from a register, not from the
// packet; a length field on air is stored as ordinary payload.
// Trade-off: memory read data is registered to keep the bus path
// short, so it lags a new memory address by one cycle.
// Preamble pulses outside packet mode are ignored, so a stray pulse
// cannot park the receiver in the search state.
module fsrx_top (
  input  wire        clk_i,         // 125 MHz system clock
  input  wire        rst_n_i,       // Synchronous reset, active low
  input  wire        wb_cyc_i,      // Wishbone cycle
  input  wire        wb_stb_i,      // Wishbone strobe
  input  wire        wb_we_i,       // Wishbone write enable
  input  wire [3:0]  wb_sel_i,      // Byte select, lane 0 used
  input  wire [11:0] wb_adr_i,      // Byte address
  input  wire [31:0] wb_dat_i,      // Write data
  output reg  [31:0] wb_dat_o,      // Read data
  output reg         wb_ack_o,      // Acknowledge
  input  wire        rx_bit_i,      // Demodulated bit from radio
  input  wire        rx_bit_en_i,   // Strobe per recovered bit, high two cycles or more to be taken
  input  wire        preamble_det_i,// Preamble qualified, one-cycle pulse
  input  wire        fsk_mode_i,    // High in FSK packet mode
  input  wire [7:0]  freq_err_i,    // Measured frequency error, signed kHz
  output reg  [7:0]  freq_corr_o,   // Applied correction, signed kHz
  output reg         fc_locked_o,   // Correction loop locked
  output reg         sync_evt_o,    // Sync-detect event line
  output reg         pkt_evt_o      // Packet-received event line
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] pkt_opt_q, sync_lo_q, sync_mid_q, sync_hi_q, sync_set_q;
  reg [7:0] discr_q, rate_up_q, rate_lo_q, postf_q, fc_set_q, fc_err_q;
  reg [7:0] fc_range_q, gain_q, en1_q, en2_q, rx_base_q, rx_count_q;
  reg [7:0] mem_addr_q, pay_len_q;
  reg [1:0] status_q;
  reg [7:0] mem [0:255];
  reg [7:0] mem_rd_q;
  wire [9:0] reg_adr = wb_adr_i[11:2];
  wire       wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wb_wr   = wb_req & wb_we_i & wb_sel_i[0];
  wire       st_clr  = wb_wr & (reg_adr == `FSRX_A_STATUS);
  // ****************************************************************
  // Pin input synchroniser, three stages
  // ****************************************************************
  // Unreset on purpose: three idle clock cycles flush any power-up value
  reg [2:0] bit_s, en_s;
  reg       en_prev_q;
  // Strobe level seen last, updated only when two stages agree
  always @(posedge clk_i) begin
    bit_s <= {bit_s[1:0], rx_bit_i};
    en_s  <= {en_s[1:0], rx_bit_en_i};
    if (en_s[2] == en_s[1])
      en_prev_q <= en_s[2];
  end
  wire bit_ok  = (bit_s[2] == bit_s[1]) ? bit_s[2] : bit_s[2];
  // Bits are retimed to the local clock; the recovery loop sets the pace
  wire bit_stb = (en_s[2] == en_s[1]) & en_s[2] & ~en_prev_q;
  // ****************************************************************
  // Sync matcher
  // ****************************************************************
  reg  [23:0] shift_q;
  wire [23:0] pattern = {sync_hi_q, sync_mid_q, sync_lo_q};
  // A length of zero still compares one bit; anything past 24 is 24
  wire [4:0]  mlen    = (sync_set_q[4:0] == 5'h00) ? `FSRX_SYNC_MIN :
                        (sync_set_q[4:0] > `FSRX_SYNC_MAX) ? `FSRX_SYNC_MAX : sync_set_q[4:0];
  // Bits above the match length never count as errors
  wire [23:0] mask    = ~(24'hffffff << mlen);
  wire [23:0] diff    = (shift_q ^ pattern) & mask;
  reg  [4:0]  errs;
  integer k;
  // Population count of the masked difference
  always @* begin
    errs = 5'h00;
    for (k = 0; k < 24; k = k + 1)
      errs = errs + {4'h0, diff[k]};
  end
  // Tolerance zero to three mismatches
  wire sync_hit = (errs <= {3'h0, sync_set_q[6:5]});
  // ****************************************************************
  // Receive state machine
  // ****************************************************************
  localparam S_IDLE = 2'h0, S_SRCH = 2'h1, S_PAY = 2'h2, S_CRC = 2'h3;
  reg [1:0]  st_q;
  reg [5:0]  bitcnt_q;
  reg [2:0]  bcnt_q;
  reg [7:0]  byte_q, wptr_q, left_q;
  reg [15:0] crc_q;
  reg [1:0]  crcb_q;
  wire [7:0] byte_n = {byte_q[6:0], bit_ok};
  wire [15:0] crc_n = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ bit_ok) ? `FSRX_CRC_POLY : 16'h0000);
  reg sync_set_ev, pkt_set_ev;
  // Event pulses last one cycle; the status flags hold them for the host
  always @(posedge clk_i) begin
    sync_set_ev <= 1'b0;
    pkt_set_ev  <= 1'b0;
    if (!rst_n_i) begin
      st_q       <= S_IDLE;
      shift_q    <= 24'h000000;
      bitcnt_q   <= 6'h00;
      bcnt_q     <= 3'h0;
      byte_q     <= `FSRX_ZERO8;
      wptr_q     <= `FSRX_ZERO8;
      left_q     <= `FSRX_ZERO8;
      crc_q      <= `FSRX_CRC_INIT;
      crcb_q     <= 2'h0;
      rx_count_q <= `FSRX_ZERO8;
    end else begin
      // The shifter runs in every state so the matcher sees history
      if (bit_stb)
        shift_q <= {shift_q[22:0], bit_ok};
      case (st_q)
        S_IDLE: begin
          // Only packet mode starts a search
          if (preamble_det_i && fsk_mode_i) begin
            st_q <= S_SRCH;
            bitcnt_q <= 6'h00;
          end
        end
        S_SRCH: begin
          if (bit_stb) begin
            bitcnt_q <= bitcnt_q + 6'h01;
            if (bitcnt_q == {`FSRX_SYNC_BYTES, 3'h0} - 6'h01)
              st_q <= S_IDLE;
          end
          // Judge the word one cycle after the shift, never on stale bits
          if (sync_hit && bitcnt_q != 6'h00 && !bit_stb) begin
            st_q <= S_PAY;
            sync_set_ev <= 1'b1;
            wptr_q <= rx_base_q;
            left_q <= pay_len_q;
            bcnt_q <= 3'h0;
            crc_q <= `FSRX_CRC_INIT;
            rx_count_q <= `FSRX_ZERO8;
          end
        end
        // Payload bytes feed the check word and the memory
        S_PAY: begin
          if (bit_stb) begin
            byte_q <= byte_n;
            bcnt_q <= bcnt_q + 3'h1;
            crc_q <= crc_n;
            if (bcnt_q == 3'h7) begin
              mem[wptr_q] <= byte_n;
              wptr_q <= wptr_q + 8'h01;
              rx_count_q <= rx_count_q + 8'h01;
              left_q <= left_q - 8'h01;
              if (left_q == 8'h01) begin
                st_q <= S_CRC;
                crcb_q <= 2'h0;
              end
            end
          end
        end
        // Two check bytes; a zero residue marks a clean packet
        S_CRC: begin
          if (bit_stb) begin
            byte_q <= byte_n;
            bcnt_q <= bcnt_q + 3'h1;
            crc_q <= crc_n;
            if (bcnt_q == 3'h7) begin
              if (pkt_opt_q[0]) begin
                mem[wptr_q] <= byte_n;
                wptr_q <= wptr_q + 8'h01;
                rx_count_q <= rx_count_q + 8'h01;
              end
              crcb_q <= crcb_q + 2'h1;
              if (crcb_q == 2'h1) begin
                st_q <= S_IDLE;
                pkt_set_ev <= ~pkt_opt_q[0] & (crc_n == 16'h0000);
              end
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // Status flags: a set in the clearing cycle wins
  // ****************************************************************
  // Event lines are the flags gated by either enable register
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= 2'h0;
      sync_evt_o <= 1'b0;
      pkt_evt_o <= 1'b0;
    end else begin
      status_q <= (status_q & ~(st_clr ? wb_dat_i[1:0] : 2'h0)) | {pkt_set_ev, sync_set_ev};
      sync_evt_o <= status_q[`FSRX_IRQ_SYNC] & (en1_q[`FSRX_IRQ_SYNC] | en2_q[`FSRX_IRQ_SYNC]);
      pkt_evt_o  <= status_q[`FSRX_IRQ_PKT] & (en1_q[`FSRX_IRQ_PKT] | en2_q[`FSRX_IRQ_PKT]);
    end
  end
  // ****************************************************************
  // Frequency correction lock and hold
  // ****************************************************************
  wire fc_auto = fsk_mode_i & (fc_set_q[1:0] == `FSRX_MODE_AUTO);
  wire signed [7:0] ferr  = freq_err_i;
  wire signed [7:0] frng  = fc_range_q;
  // Range is in 1 kHz steps, the same unit as the measured error
  wire signed [7:0] fclip = (ferr > frng) ? frng : (ferr < -frng) ? -frng : ferr;
  // Correction persists across state changes until replaced or cleared
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      fc_locked_o <= 1'b0;
      freq_corr_o <= `FSRX_ZERO8;
      fc_err_q <= `FSRX_ZERO8;
    end else begin
      if (!fc_locked_o)
        fc_err_q <= freq_err_i;
      if (fc_range_q == `FSRX_ZERO8 && fc_set_q[1:0] == `FSRX_MODE_CLEAR)
        freq_corr_o <= `FSRX_ZERO8;
      else if (fc_auto && !fc_locked_o && st_q == S_IDLE)
        freq_corr_o <= fclip;
      if (!fc_auto)
        fc_locked_o <= 1'b0;
      else if (preamble_det_i && st_q == S_IDLE)
        fc_locked_o <= 1'b1;
      else if (st_q == S_SRCH && bit_stb &&
               bitcnt_q == {`FSRX_SYNC_BYTES, 3'h0} - 6'h01)
        fc_locked_o <= 1'b0;
      else if (st_q == S_CRC && bit_stb && bcnt_q == 3'h7 && crcb_q == 2'h1)
        fc_locked_o <= 1'b0;
    end
  end
  // ****************************************************************
  // Wishbone slave: one-cycle ack, unmapped reads zero
  // ****************************************************************
  // Ack never stands two cycles; a request held past ack is taken again every second cycle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      pkt_opt_q  <= `FSRX_ZERO8;
      sync_lo_q  <= `FSRX_ZERO8;
      sync_mid_q <= `FSRX_ZERO8;
      sync_hi_q  <= `FSRX_ZERO8;
      sync_set_q <= `FSRX_SYNC_RESET;
      discr_q    <= `FSRX_ZERO8;
      rate_up_q  <= `FSRX_ZERO8;
      rate_lo_q  <= `FSRX_ZERO8;
      postf_q    <= `FSRX_ZERO8;
      fc_set_q   <= `FSRX_ZERO8;
      fc_range_q <= `FSRX_ZERO8;
      gain_q     <= `FSRX_GAIN_RESET;
      en1_q      <= `FSRX_ZERO8;
      en2_q      <= `FSRX_ZERO8;
      rx_base_q  <= `FSRX_ZERO8;
      mem_addr_q <= `FSRX_ZERO8;
      pay_len_q  <= `FSRX_PAY_RESET;
      mem_rd_q   <= `FSRX_ZERO8;
    end else begin
      wb_ack_o <= wb_req;
      // Registered memory read, one cycle behind the address
      mem_rd_q <= mem[mem_addr_q];
      // Writes land on the taking edge; lane 0 only
      if (wb_wr) begin
        case (reg_adr)
          `FSRX_A_PKT_OPT:  pkt_opt_q  <= wb_dat_i[7:0];
          `FSRX_A_SYNC_LO:  sync_lo_q  <= wb_dat_i[7:0];
          `FSRX_A_SYNC_MID: sync_mid_q <= wb_dat_i[7:0];
          `FSRX_A_SYNC_HI:  sync_hi_q  <= wb_dat_i[7:0];
          `FSRX_A_SYNC_SET: sync_set_q <= wb_dat_i[7:0];
          `FSRX_A_DISCR:    discr_q    <= wb_dat_i[7:0];
          `FSRX_A_RATE_UP:  rate_up_q  <= wb_dat_i[7:0];
          `FSRX_A_RATE_LO:  rate_lo_q  <= wb_dat_i[7:0];
          `FSRX_A_POSTF:    postf_q    <= wb_dat_i[7:0];
          `FSRX_A_FC_SET:   fc_set_q   <= wb_dat_i[7:0];
          `FSRX_A_FC_RANGE: fc_range_q <= wb_dat_i[7:0];
          `FSRX_A_GAIN:     gain_q     <= wb_dat_i[7:0];
          `FSRX_A_IRQ_EN1:  en1_q      <= wb_dat_i[7:0];
          `FSRX_A_IRQ_EN2:  en2_q      <= wb_dat_i[7:0];
          `FSRX_A_RX_BASE:  rx_base_q  <= wb_dat_i[7:0];
          `FSRX_A_MEM_ADDR: mem_addr_q <= wb_dat_i[7:0];
          `FSRX_A_PAY_LEN:  pay_len_q  <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      // Read mux runs every cycle; the data is valid with ack
      case (reg_adr)
        `FSRX_A_PKT_OPT:  wb_dat_o <= {24'h0, pkt_opt_q};
        `FSRX_A_SYNC_LO:  wb_dat_o <= {24'h0, sync_lo_q};
        `FSRX_A_SYNC_MID: wb_dat_o <= {24'h0, sync_mid_q};
        `FSRX_A_SYNC_HI:  wb_dat_o <= {24'h0, sync_hi_q};
        `FSRX_A_SYNC_SET: wb_dat_o <= {24'h0, sync_set_q};
        `FSRX_A_DISCR:    wb_dat_o <= {25'h0, discr_q[6:0]};
        `FSRX_A_RATE_UP:  wb_dat_o <= {24'h0, rate_up_q};
        `FSRX_A_RATE_LO:  wb_dat_o <= {24'h0, rate_lo_q};
        `FSRX_A_POSTF:    wb_dat_o <= {24'h0, postf_q};
        `FSRX_A_FC_SET:   wb_dat_o <= {24'h0, fc_set_q};
        `FSRX_A_FC_ERR:   wb_dat_o <= {24'h0, fc_err_q};
        `FSRX_A_FC_RANGE: wb_dat_o <= {24'h0, fc_range_q};
        `FSRX_A_GAIN:     wb_dat_o <= {24'h0, gain_q};
        `FSRX_A_IRQ_EN1:  wb_dat_o <= {24'h0, en1_q};
        `FSRX_A_IRQ_EN2:  wb_dat_o <= {24'h0, en2_q};
        `FSRX_A_STATUS:   wb_dat_o <= {30'h0, status_q};
        `FSRX_A_RX_BASE:  wb_dat_o <= {24'h0, rx_base_q};
        `FSRX_A_RX_COUNT: wb_dat_o <= {24'h0, rx_count_q};
        `FSRX_A_MEM_ADDR: wb_dat_o <= {24'h0, mem_addr_q};
        `FSRX_A_MEM_DATA: wb_dat_o <= {24'h0, mem_rd_q};
        `FSRX_A_PAY_LEN:  wb_dat_o <= {24'h0, pay_len_q};
        default:          wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule // fsrx_top
`default_nettype wire

//--- logic/fsrx_defines.vh
// Constants for the FSK receive back end: register map, fields, timing.
`ifndef FSRX_DEFINES_VH
`define FSRX_DEFINES_VH
// ****************************************************************
// Register word indices (times four for the byte address on the bus)
// ****************************************************************
`define FSRX_A_PKT_OPT    10'h108
`define FSRX_A_SYNC_LO    10'h10c
`define FSRX_A_SYNC_MID   10'h10d
`define FSRX_A_SYNC_HI    10'h10e
`define FSRX_A_SYNC_SET   10'h10f
`define FSRX_A_DISCR      10'h305
`define FSRX_A_RATE_UP    10'h30e
`define FSRX_A_RATE_LO    10'h30f
`define FSRX_A_POSTF      10'h38b
`define FSRX_A_FC_SET     10'h3f7
`define FSRX_A_FC_ERR     10'h3fa
`define FSRX_A_FC_RANGE   10'h3f8
`define FSRX_A_GAIN       10'h3f9
`define FSRX_A_IRQ_EN1    10'h3e0
`define FSRX_A_IRQ_EN2    10'h3e1
`define FSRX_A_STATUS     10'h3e2
`define FSRX_A_RX_BASE    10'h3e3
`define FSRX_A_RX_COUNT   10'h3e4
`define FSRX_A_MEM_ADDR   10'h3e5
`define FSRX_A_MEM_DATA   10'h3e6
`define FSRX_A_PAY_LEN    10'h3e7
// ****************************************************************
// Fields and values
// ****************************************************************
`define FSRX_IRQ_SYNC     0
`define FSRX_IRQ_PKT      1
`define FSRX_MODE_AUTO    2'h3
`define FSRX_MODE_CLEAR   2'h2
`define FSRX_PREAMBLE     8'haa
`define FSRX_SYNC_BYTES   3'h4
`define FSRX_CRC_INIT     16'h0000
`define FSRX_CRC_POLY     16'h1021
`define FSRX_GAIN_RESET   8'h99
`define FSRX_PAY_RESET    8'h04
`define FSRX_ZERO8        8'h00
`define FSRX_SYNC_RESET   8'h18
`define FSRX_SYNC_MAX     5'd24
`define FSRX_SYNC_MIN     5'h01
`endif

//--- verif/fsrx_tx_model.sv
// Remote transmitter model driving the bit strobe link of the receive back end.
`timescale 1ns/100ps
`default_nettype none
module fsrx_tx_model (
  input  wire logic clk_i, // System clock
  output var  logic bit_o, // Bit line
  output var  logic en_o,  // Bit strobe
  output var  logic pre_o  // Preamble qualified pulse
);
  logic idle_q = 1'b1; // No frame on air
  // Quiet link at time zero
  initial begin
    bit_o = 1'b0;
    en_o = 1'b0;
    pre_o = 1'b0;
  end
  // Idle line flips so a stale sample never passes for data
  always @(negedge clk_i) if (idle_q) bit_o <= ~bit_o;
  // Each level stands eight cycles, strobe high for the first four, longer than the three-stage input synchroniser
  task automatic snd(input logic [47:0] v, input int n);
    idle_q = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      bit_o <= v[i];
      en_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      en_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    idle_q = 1'b1;
  endtask
  // One-cycle preamble qualification
  task automatic pulse();
    pre_o <= 1'b1;
    @(posedge clk_i);
    pre_o <= 1'b0;
  endtask
  // Preamble, pulse, sync word high byte first, then payload and check word
  task automatic frame(input logic [23:0] s, input logic [47:0] p);
    snd(48'haaaa, 16);
    pulse();
    snd({24'h0, s}, 24);
    snd(p, 48);
  endtask
endmodule // fsrx_tx_model
`default_nettype wire

//--- verif/fsrx_top_chk.sv
// Port checker for the FSK receive back end.
`timescale 1ns/100ps
`default_nettype none
module fsrx_top_chk (
  input wire logic        clk_i,          // Clock
  input wire logic        rst_n_i,        // Reset
  input wire logic        wb_cyc_i,       // Cycle
  input wire logic        wb_stb_i,       // Strobe
  input wire logic        wb_we_i,        // Write
  input wire logic [31:0] wb_dat_o,       // Read data
  input wire logic        wb_ack_o,       // Ack
  input wire logic        preamble_det_i, // Preamble
  input wire logic        fsk_mode_i,     // FSK mode
  input wire logic [7:0]  freq_corr_o,    // Correction
  input wire logic        fc_locked_o,    // Locked
  input wire logic        sync_evt_o,     // Sync event
  input wire logic        pkt_evt_o       // Packet event
);
  // *****
  // Ages
  // *****
  logic [3:0] wr_age_q, pre_age_q; // Since write request, since FSK preamble
  // Ages saturate so long idle spans cannot wrap into a false pass
  always @(posedge clk_i) begin
    if (!rst_n_i || (wb_cyc_i && wb_stb_i && wb_we_i)) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
    if (!rst_n_i) pre_age_q <= 4'hf;
    else if (preamble_det_i && fsk_mode_i) pre_age_q <= 4'h0;
    else if (pre_age_q != 4'hf) pre_age_q <= pre_age_q + 4'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  rd_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
  lock_cause_a: assert property ($rose(fc_locked_o) |-> pre_age_q <= 4'h3) else $error("bad lock");
  corr_hold_a: assert property (fc_locked_o && $past(fc_locked_o) |-> $stable(freq_corr_o)) else $error("moved");
  sync_fall_a: assert property ($fell(sync_evt_o) |-> wr_age_q <= 4'h4) else $error("sync lost");
  pkt_fall_a: assert property ($fell(pkt_evt_o) |-> wr_age_q <= 4'h4) else $error("pkt lost");
  both_evt_c: cover property (sync_evt_o && pkt_evt_o);
  lock_on_c: cover property ($rose(fc_locked_o));
  lock_off_c: cover property ($fell(fc_locked_o));
endmodule // fsrx_top_chk
bind fsrx_top fsrx_top_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .preamble_det_i(preamble_det_i),
  .fsk_mode_i(fsk_mode_i), .freq_corr_o(freq_corr_o), .fc_locked_o(fc_locked_o), .sync_evt_o(sync_evt_o),
  .pkt_evt_o(pkt_evt_o));
`default_nettype wire

//--- verif/fsrx_top_bench.sv
// Self-checking bench for the FSK receive back end.
`timescale 1ns/100ps
`default_nettype none
`include "fsrx_defines.vh"
module fsrx_top_bench;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, fsk = 1;
  logic [3:0] sel = 4'h1;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0, rdat, ev, rs = 32'hd;
  logic [7:0] ferr = 8'h0, corr;
  logic ack, lock, sevt, pevt, bit_w, en_w, pre_w;
  logic [23:0] pat;
  logic [47:0] pay;
  logic [31:0] exp_q[$];
  logic [9:0] ra[5] = '{`FSRX_A_DISCR, `FSRX_A_GAIN, `FSRX_A_POSTF, `FSRX_A_RATE_UP, `FSRX_A_RATE_LO};
  logic [7:0] rv[5] = '{8'h0a, 8'h99, 8'h3a, 8'h01, 8'hf4};
  int bad_count = 0, checks_done = 0;
  fsrx_top dut (.clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_bit_i(bit_w), .rx_bit_en_i(en_w),
    .preamble_det_i(pre_w), .fsk_mode_i(fsk), .freq_err_i(ferr), .freq_corr_o(corr), .fc_locked_o(lock),
    .sync_evt_o(sevt), .pkt_evt_o(pevt));
  fsrx_tx_model tx (.clk_i(clk), .bit_o(bit_w), .en_o(en_w), .pre_o(pre_w));
  // 125 MHz clock
  always #4 clk = ~clk;
  // *****
  // Helpers
  // *****
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Check word over 32 payload bits, MSB first
  function logic [15:0] crc(input logic [31:0] d);
    logic [15:0] c;
    c = 16'h0;
    for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
    return c;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Classic cycle: held until ack is sampled, then one idle cycle
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(a, 1'b0, 8'h0);
  endtask
  // Read results are judged in issue order
  always @(posedge clk) if (ack === 1'b1 && we === 1'b0) begin
    ev = exp_q.pop_front();
    chk("rdata", ev, rdat);
  end
  // One frame with chosen sync errors and check word damage
  task automatic pkt(input logic [23:0] err, input logic [15:0] cx, input logic es, input logic ep);
    pay = {rnd(), 16'h0};
    pay[15:0] = crc(pay[47:16]) ^ cx;
    tx.frame(pat ^ err, pay);
    repeat (30) @(posedge clk);
    chk("sync_evt", 32'(es), 32'(sevt));
    chk("pkt_evt", 32'(ep), 32'(pevt));
    if (es) for (int i = 0; i < 4; i++) begin
      bus(`FSRX_A_MEM_ADDR, 1'b1, 8'h10 + i[7:0]);
      rd(`FSRX_A_MEM_DATA, pay[47 - 8 * i -: 8]);
    end
    bus(`FSRX_A_STATUS, 1'b1, 8'h3);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog at 50,000 cycles, well beyond the expected 6,500 or so
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  // *****
  // Main sequence
  // *****
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`FSRX_A_GAIN, `FSRX_GAIN_RESET);
    rd(`FSRX_A_PAY_LEN, `FSRX_PAY_RESET);
    rd(`FSRX_A_SYNC_SET, 8'h18);
    rd(10'h3ff, 8'h0);
    sel <= 4'h0;
    bus(`FSRX_A_GAIN, 1'b1, 8'h00);
    sel <= 4'h1;
    rd(`FSRX_A_GAIN, 8'h99);
    foreach (ra[i]) bus(ra[i], 1'b1, rv[i]);
    foreach (ra[i]) rd(ra[i], rv[i]);
    pat = {16'(rnd()), 8'h0f};
    bus(`FSRX_A_SYNC_HI, 1'b1, pat[23:16]);
    bus(`FSRX_A_SYNC_MID, 1'b1, pat[15:8]);
    bus(`FSRX_A_SYNC_LO, 1'b1, pat[7:0]);
    rd(`FSRX_A_SYNC_HI, pat[23:16]);
    bus(`FSRX_A_RX_BASE, 1'b1, 8'h10);
    bus(`FSRX_A_IRQ_EN1, 1'b1, 8'h1);
    bus(`FSRX_A_IRQ_EN2, 1'b1, 8'h2);
    bus(`FSRX_A_PKT_OPT, 1'b1, 8'h0);
    for (int t = 0; t < 4; t++) begin
      bus(`FSRX_A_SYNC_SET, 1'b1, {1'b0, t[1:0], 5'd24});
      pkt(24'h7 >> (3 - t), 16'h0, 1'b1, 1'b1);
    end
    bus(`FSRX_A_SYNC_SET, 1'b1, 8'h38);
    pkt(24'h3, 16'h0, 1'b0, 1'b0);
    bus(`FSRX_A_SYNC_SET, 1'b1, 8'h08);
    pkt({pat[23:8] ^ 16'haaaa, 8'h0}, 16'h0, 1'b1, 1'b1);
    bus(`FSRX_A_SYNC_SET, 1'b1, 8'h18);
    pkt(24'h0, 16'h1, 1'b1, 1'b0);
    bus(`FSRX_A_PKT_OPT, 1'b1, 8'h1);
    pkt(24'h0, 16'h0, 1'b1, 1'b0);
    bus(`FSRX_A_MEM_ADDR, 1'b1, 8'h15);
    rd(`FSRX_A_MEM_DATA, pay[7:0]);
    bus(`FSRX_A_PKT_OPT, 1'b1, 8'h0);
    // Correction: follow and clamp, lock, hold, search timeout, clear
    bus(`FSRX_A_FC_RANGE, 1'b1, 8'h20);
    bus(`FSRX_A_FC_SET, 1'b1, {6'h0, `FSRX_MODE_AUTO});
    ferr <= 8'hc0;
    repeat (8) @(posedge clk);
    chk("corr", 32'he0, 32'(corr));
    rd(`FSRX_A_FC_ERR, 8'hc0);
    fsk <= 1'b0;
    tx.pulse();
    repeat (4) @(posedge clk);
    chk("lock", 32'h0, 32'(lock));
    fsk <= 1'b1;
    tx.pulse();
    ferr <= 8'h05;
    repeat (4) @(posedge clk);
    chk("lock", 32'h1, 32'(lock));
    rd(`FSRX_A_FC_ERR, 8'hc0);
    tx.snd(48'h0, 31);
    chk("lock", 32'h1, 32'(lock));
    tx.snd(48'h0, 2);
    repeat (4) @(posedge clk);
    chk("lock", 32'h0, 32'(lock));
    chk("corr", 32'h05, 32'(corr));
    bus(`FSRX_A_FC_RANGE, 1'b1, 8'h00);
    bus(`FSRX_A_FC_SET, 1'b1, {6'h0, `FSRX_MODE_CLEAR});
    repeat (4) @(posedge clk);
    chk("corr", 32'h0, 32'(corr));
    stop_test();
  end
endmodule // fsrx_top_bench
`default_nettype wire
